/* File: design/pit_pkg.sv */
// Package for the periodic interrupt timer: register map, field layout,
// reset values. Assumes 32-bit APB with one aligned word per register.
package pit_pkg;
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [7:0] ADDR_MODULO_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_MODULO_LOW = 8'h10;
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h14;
    // Status/control field positions
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_COUNTER_STOP = 5;
    localparam int BIT_COUNTER_RESET = 4;
    localparam int BIT_PRESCALER_MSB = 2;
    // Mode control field positions
    localparam int BIT_WAIT = 0;
    localparam int BIT_STOP = 1;
    localparam int BIT_BREAK = 2;
    localparam int BIT_BREAK_CLEAR = 3;
    localparam logic [15:0] RESET_MODULO = 16'hffff;
    localparam logic [2:0] RESET_PRESCALER = 3'h0;
    localparam logic [5:0] PRESCALER_MAX = 6'h3f;
endpackage

/* File: design/pit_timer.sv */
// Periodic interrupt timer: 16-bit modulo up-counter with prescaler,
// overflow flag and interrupt. Assumes an APB master on REF_CLK and that
// wait, stop, break and break-clear-enable levels come from outside.
`timescale 1ns/10ps
module pit_timer (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);
    // Mode levels held in a register of their own, set by the system
    logic [3:0] mode;
    logic [15:0] count;
    logic [5:0] prescale;
    logic [15:0] modulo;
    logic [7:0] low_latch;
    logic latched;
    logic overflow_flag;
    logic clear_armed;
    logic irq_enable;
    logic counter_stop;
    logic [2:0] prescaler_select;
    logic modulo_inhibit;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;

    logic [3:0] next_mode;
    logic [15:0] next_count;
    logic [5:0] next_prescale;
    logic [15:0] next_modulo;
    logic [7:0] next_low_latch;
    logic next_latched;
    logic next_overflow_flag;
    logic next_clear_armed;
    logic next_irq_enable;
    logic next_counter_stop;
    logic [2:0] next_prescaler_select;
    logic next_modulo_inhibit;
    logic [31:0] next_rdata;
    logic next_ready;
    logic next_slverr;
    logic next_irq;

    logic access;
    logic wr;
    logic rd;
    logic tick;
    logic run;
    logic overflow;
    logic in_wait;
    logic in_break;
    logic flag_clear_ok;

    // Prescaler terminal mask per select code
    function automatic logic [5:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0: div_mask = 6'h00;
            3'h1: div_mask = 6'h01;
            3'h2: div_mask = 6'h03;
            3'h3: div_mask = 6'h07;
            3'h4: div_mask = 6'h0f;
            3'h5: div_mask = 6'h1f;
            default: div_mask = pit_pkg::PRESCALER_MAX;
        endcase
    endfunction

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] b);
        is_addr = (a == b);
    endfunction

    assign in_wait = mode[pit_pkg::BIT_WAIT];
    assign in_break = mode[pit_pkg::BIT_BREAK];
    assign flag_clear_ok = !in_break || mode[pit_pkg::BIT_BREAK_CLEAR];
    // Mode control stays reachable in wait so the system can leave it
    assign access = PSEL && PENABLE && !ready;
    assign wr = access && PWRITE;
    assign rd = access && !PWRITE;
    // only stop, stop mode and break freeze it
    assign run = !counter_stop && !mode[pit_pkg::BIT_STOP] && !in_break;
    assign tick = run
        && ((prescale & div_mask(prescaler_select)) ==
            div_mask(prescaler_select));
    assign overflow = tick && (count == modulo) && !modulo_inhibit;

    always_comb begin
        logic wait_block;
        logic ctl_write;
        wait_block = 1'b0;
        ctl_write = 1'b0;
        next_mode = mode;
        next_count = count;
        next_prescale = prescale;
        next_modulo = modulo;
        next_low_latch = low_latch;
        next_latched = latched;
        next_overflow_flag = overflow_flag;
        next_clear_armed = clear_armed;
        next_irq_enable = irq_enable;
        next_counter_stop = counter_stop;
        next_prescaler_select = prescaler_select;
        next_modulo_inhibit = modulo_inhibit;
        next_rdata = 32'h0000_0000;
        next_ready = access;
        next_slverr = 1'b0;

        if (run) begin
            next_prescale = tick ? 6'h00 : prescale + 6'h01;
        end
        if (tick) begin
            next_count = (count == modulo) ? 16'h0000 : count + 16'h0001;
        end

        // timer registers refused while processor waits
        wait_block = in_wait
            && !is_addr(PADDR, pit_pkg::ADDR_MODE_CONTROL);
        if (access && wait_block) begin
            next_slverr = 1'b1;
        end else if (rd) begin
            case (PADDR)
                pit_pkg::ADDR_STATUS_CONTROL: begin
                    next_rdata[7:0] = {overflow_flag, irq_enable,
                                       counter_stop, 1'b0, 1'b0,
                                       prescaler_select};
                    if (overflow_flag && flag_clear_ok) begin
                        next_clear_armed = 1'b1;
                    end
                end
                pit_pkg::ADDR_COUNT_HIGH: begin
                    next_rdata[7:0] = count[15:8];
                    if (!latched) begin
                        next_latched = 1'b1;
                        next_low_latch = count[7:0];
                    end
                end
                pit_pkg::ADDR_COUNT_LOW: begin
                    next_rdata[7:0] = latched ? low_latch : count[7:0];
                    next_latched = 1'b0;
                end
                pit_pkg::ADDR_MODULO_HIGH: next_rdata[7:0] = modulo[15:8];
                pit_pkg::ADDR_MODULO_LOW: next_rdata[7:0] = modulo[7:0];
                pit_pkg::ADDR_MODE_CONTROL: next_rdata[3:0] = mode;
                default: next_slverr = 1'b1;
            endcase
        end else if (wr) begin
            case (PADDR)
                pit_pkg::ADDR_STATUS_CONTROL: begin
                    ctl_write = 1'b1;
                    next_irq_enable = PWDATA[pit_pkg::BIT_IRQ_ENABLE];
                    next_counter_stop = PWDATA[pit_pkg::BIT_COUNTER_STOP];
                    next_prescaler_select =
                        PWDATA[pit_pkg::BIT_PRESCALER_MSB:0];
                    if (PWDATA[pit_pkg::BIT_COUNTER_RESET]) begin
                        next_count = 16'h0000;
                        next_prescale = 6'h00;
                        next_latched = 1'b0;
                    end
                end
                pit_pkg::ADDR_MODULO_HIGH: begin
                    next_modulo[15:8] = PWDATA[7:0];
                    next_modulo_inhibit = 1'b1;
                end
                pit_pkg::ADDR_MODULO_LOW: begin
                    next_modulo[7:0] = PWDATA[7:0];
                    next_modulo_inhibit = 1'b0;
                end
                pit_pkg::ADDR_MODE_CONTROL: next_mode = PWDATA[3:0];
                pit_pkg::ADDR_COUNT_HIGH,
                pit_pkg::ADDR_COUNT_LOW: next_slverr = 1'b0;
                default: next_slverr = 1'b1;
            endcase
        end

        // zero write clears only an armed flag
        if (ctl_write && !PWDATA[pit_pkg::BIT_OVERFLOW_FLAG]
            && clear_armed && flag_clear_ok) begin
            next_overflow_flag = 1'b0;
            next_clear_armed = 1'b0;
        end
        if (overflow) begin
            next_overflow_flag = 1'b1;
            next_clear_armed = 1'b0;
        end
        next_irq = next_overflow_flag && next_irq_enable;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mode <= 4'h0;
            count <= 16'h0000;
            prescale <= 6'h00;
            modulo <= pit_pkg::RESET_MODULO;
            low_latch <= 8'h00;
            latched <= 1'b0;
            overflow_flag <= 1'b0;
            clear_armed <= 1'b0;
            irq_enable <= 1'b0;
            counter_stop <= 1'b1;
            prescaler_select <= pit_pkg::RESET_PRESCALER;
            modulo_inhibit <= 1'b0;
            rdata <= 32'h0000_0000;
            ready <= 1'b0;
            slverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            mode <= next_mode;
            count <= next_count;
            prescale <= next_prescale;
            modulo <= next_modulo;
            low_latch <= next_low_latch;
            latched <= next_latched;
            overflow_flag <= next_overflow_flag;
            clear_armed <= next_clear_armed;
            irq_enable <= next_irq_enable;
            counter_stop <= next_counter_stop;
            prescaler_select <= next_prescaler_select;
            modulo_inhibit <= next_modulo_inhibit;
            rdata <= next_rdata;
            ready <= next_ready;
            slverr <= next_slverr;
            irq <= next_irq;
        end
    end

    assign PRDATA = rdata;
    assign PREADY = ready;
    assign PSLVERR = slverr;
    assign IRQ = irq;
endmodule // pit_timer

/* File: test/pit_cpu_model.sv */
// APB master standing in for the processor core.
// Assumes the slave answers on REF_CLK; a hang sets hung.
`timescale 1ns/10ps
module pit_cpu_model (
    input wire logic REF_CLK,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [7:0] PADDR,
    output logic [31:0] PWDATA
);
    logic hung = 1'b0;
    initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        hung |= (n >= 50);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Released lines carry garbage, not the old request
        PADDR <= ~a;
        PWDATA <= ~d;
    endtask
endmodule // pit_cpu_model

/* File: test/pit_timer_bench.sv */
// Self-checking bench for the periodic interrupt timer.
// Assumes the APB master model and the port checker beside it.
`timescale 1ns/10ps
module pit_timer_bench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int error_cnt = 0;
    int comparisons = 0;
    pit_timer i_pit_timer (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    pit_cpu_model i_pit_cpu_model (.REF_CLK(clk), .PREADY(pready),
        .PSLVERR(pslverr), .PRDATA(prdata), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        error_cnt += int'(i_pit_cpu_model.hung);
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_pit_cpu_model.xfer(w, a, {24'h0, d}, q, e);
        if (i_pit_cpu_model.hung === 1'b1) report_and_stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        io(1'b0, a, 8'h00);
    endtask
    task automatic rd_cnt();
        rd(8'h04);
        rd(8'h08);
    endtask
    task automatic setup(input logic [15:0] m, input logic [7:0] ctl);
        wr(8'h00, 8'h30);
        wr(8'h0c, m[15:8]);
        wr(8'h10, m[7:0]);
        wr(8'h00, ctl);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic t_reset();
        rd(8'h00);
        chk(q, 32'h20);
        rd(8'h0c);
        chk(q, 32'hff);
        rd(8'h10);
        chk(q, 32'hff);
        rd(8'h18);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_overflow();
        setup(16'h0040, 8'h40);
        wait_irq();
        wr(8'h00, 8'hc0);
        rd(8'h00);
        chk(q, 32'hc0);
        wr(8'h00, 8'h40);
        rd(8'h00);
        chk(q, 32'h40);
        // Short period so that an overflow lands between the two steps
        setup(16'h0010, 8'h40);
        wait_irq();
        rd(8'h00);
        repeat (20) @(posedge clk);
        wr(8'h00, 8'h60);
        rd(8'h00);
        chk(q, 32'he0);
        $display("test overflow done");
    endtask
    task automatic t_presc();
        int dv;
        for (int c = 0; c < 8; c++) begin
            dv = 1 << ((c == 7) ? 6 : c);
            setup(16'hffff, 8'(c));
            repeat (16 * dv) @(posedge clk);
            rd_cnt();
            chk({31'h0, q >= 15 && q <= 17 + 8 / dv}, 32'h1);
        end
        $display("test prescaler done");
    endtask
    task automatic t_wait();
        logic [31:0] v;
        setup(16'hffff, 8'h00);
        rd_cnt();
        v = q;
        wr(8'h14, 8'h01);
        wr(8'h0c, 8'h12);
        chk({31'h0, e}, 32'h1);
        repeat (40) @(posedge clk);
        wr(8'h14, 8'h00);
        rd(8'h0c);
        chk(q, 32'hff);
        rd_cnt();
        // Frozen in wait would leave it short of the 40 idle cycles
        chk({31'h0, q >= v + 32'd40}, 32'h1);
        $display("test wait done");
    endtask
    task automatic t_break();
        logic [31:0] v;
        setup(16'h0040, 8'h40);
        wait_irq();
        rd(8'h00);
        wr(8'h14, 8'h04);
        rd_cnt();
        v = q;
        wr(8'h00, 8'h40);
        rd_cnt();
        chk(q, v);
        chk({31'h0, irq}, 32'h1);
        wr(8'h14, 8'h02);
        rd_cnt();
        chk(q, v);
        wr(8'h14, 8'h00);
        wr(8'h00, 8'h40);
        rd(8'h00);
        chk(q, 32'h40);
        wait_irq();
        wr(8'h14, 8'h0c);
        rd(8'h00);
        wr(8'h00, 8'h40);
        wr(8'h14, 8'h00);
        rd(8'h00);
        chk(q, 32'h40);
        $display("test break done");
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_overflow();
        t_presc();
        t_wait();
        t_break();
        report_and_stop();
    end
endmodule // pit_timer_bench
bind pit_timer pit_timer_properties i_pit_timer_properties (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

/* File: test/pit_timer_properties.sv */
// Checker on the timer's APB and interrupt ports.
// Assumes a master that holds PADDR and PWDATA until PREADY.
`timescale 1ns/10ps
module pit_timer_properties (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    logic in_wait;
    logic next_in_wait;
    wire fin = PSEL && PREADY && !PSLVERR;
    wire st_rd = fin && !PWRITE && PADDR == 8'h00;
    // Mirror of the wait level, since the port view cannot see it
    always_comb begin
        next_in_wait = in_wait;
        if (!RST_N)
            next_in_wait = 1'b0;
        else if (fin && PWRITE && PADDR == 8'h14)
            next_in_wait = PWDATA[0];
    end
    always_ff @(posedge REF_CLK) begin
        in_wait <= next_in_wait;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_reset_quiet: assert property (
        $rose(RST_N) |-> !PREADY && !IRQ && PRDATA == 32'h0)
        else $error("outputs busy after reset");
    a_one_wait: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("access not answered after one wait state");
    a_wait_refused: assert property (
        PSEL && PREADY && in_wait && PADDR != 8'h14 |-> PSLVERR)
        else $error("access served in wait mode");
    a_unmapped_err: assert property (
        PSEL && PREADY && PADDR > 8'h14 |-> PSLVERR)
        else $error("unmapped access not refused");
    a_reset_bit_zero: assert property (
        st_rd |-> PRDATA[4] == 1'b0)
        else $error("counter reset bit read as one");
    a_irq_status: assert property (
        st_rd |-> $past(IRQ) == (PRDATA[7] && PRDATA[6]))
        else $error("request differs from flag and enable");
    a_irq_disable: assert property (
        fin && PWRITE && PADDR == 8'h00 && !PWDATA[6] |-> ##[1:2] !IRQ)
        else $error("request stays up after disable");
    a_ready_in_access: assert property (
        PREADY |-> $past(PSEL) && $past(PENABLE))
        else $error("answer without an access");
    c_refused: cover property (PSEL && PREADY && PSLVERR);
    c_irq: cover property ($rose(IRQ));
    c_status: cover property (st_rd && PRDATA[7]);
endmodule // pit_timer_properties
